/* rtl/usbep_ctrl.sv */
// endpoint control registers with apb slave and sie handshake logic
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - auto nak sets forced nak after success
// - short enable sends short, clears after short
// - short enable with empty fifo sends zlp
// - short received packet sets nak unless disabled
// - auto nak on complete has priority
// - toggle status bit reads live toggle
// - toggle set/clear commands, clear wins
// - forced nak answers every transaction nak
// - nak write deferred until transaction ends
// - forced stall answers stall, beats nak
// - late stall applies from next transaction
// - packet limit is eleven bits, split
// - direction bit zero out, one in
// - in mode bit picks always toggle
// - out mode bit selects ping behaviour
// - iso bit selects isochronous transfers
module usbep_ctrl
   import usbep_pkg::*;
#(
   parameter int ADDR_W = USBEP_ADDR_W
)(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // second endpoint transaction events from the sie
   input wire logic b_txn_start,
   input wire logic b_txn_done,
   input wire logic b_txn_ok,
   input wire logic b_dir_in,
   input wire logic b_short,
   input wire logic b_fifo_empty,
   // second endpoint answers to the sie
   output usbep_reply_t b_reply,
   output logic b_send_short,
   output logic b_send_zlp,
   output logic b_toggle,
   // third endpoint transaction events from the sie
   input wire logic c_txn_done,
   input wire logic c_txn_ok,
   // third endpoint configuration to the sie
   output logic [USBEP_LIM_W-1:0] c_packet_limit,
   output logic c_dir_in,
   output logic c_periodic_mode,
   output logic c_ping_enable,
   output logic c_iso,
   output logic [3:0] c_index,
   output logic c_toggle
);
   // register state of the block, apart from the reply and toggle submodules
   typedef struct packed {
      logic auto_nak;                  // nak after each good transaction
      logic short_en;                  // short packet permitted
      logic srx_dis;                   // short receive nak disabled
      logic forced_nak;                // nak override
      logic nak_pending;               // nak write held off
      logic forced_halt;               // stall override
      logic tgl_one;                   // toggle set pulse
      logic tgl_zero;                  // toggle clear pulse
      logic send_zlp;                  // zero length answer armed
      logic [USBEP_LIM_W-1:0] limit;   // third endpoint packet limit
      logic dir_in;                    // third endpoint direction
      logic periodic;                  // third endpoint mode bit
      logic ping;                      // ping flow control wanted
      logic iso;                       // third endpoint isochronous
      logic [3:0] index;               // third endpoint number
      logic pready;                    // apb answer strobe
      logic pslverr;                   // apb error flag
      logic [31:0] prdata;             // apb read data
   } usbep_top_t;

   usbep_top_t s_ff, nxt_s;

   // submodule outputs
   usbep_reply_t rpl_code;
   logic rpl_active;
   logic tgl_b;
   logic tgl_c;

   // bus decode
   logic [9:0] idx;
   logic acc;
   logic mapped;
   logic wr_fire;
   logic wr_ctrl;
   logic wr_lim_hi;
   logic wr_lim_lo;
   logic wr_cfg;
   logic [7:0] rd_byte;
   logic txn_busy;
   logic b_good;
   logic [7:0] wb;

   // word index from the byte address; low two bits do not matter
   assign idx = paddr[11:2];
   assign acc = psel && penable;
   assign wb = pwdata[7:0];

   // address decode and read multiplexer
   always_comb begin
      mapped = 1'b1;
      rd_byte = 8'h00;
      case (idx)
         USBEP_IDX_B_CTRL: begin
            rd_byte[USBEP_B_AUTO_NAK] = s_ff.auto_nak;
            rd_byte[USBEP_B_SHORT_EN] = s_ff.short_en;
            rd_byte[USBEP_B_SRX_DIS] = s_ff.srx_dis;
            // live toggle, command bits read zero
            rd_byte[USBEP_B_TOGGLE] = tgl_b;
            rd_byte[USBEP_B_NAK] = s_ff.forced_nak;
            rd_byte[USBEP_B_HALT] = s_ff.forced_halt;
         end
         USBEP_IDX_C_LIM_HI: begin
            // reserved upper five bits read zero
            rd_byte[USBEP_LIM_HI_W-1:0] =
               s_ff.limit[USBEP_LIM_W-1:8];
         end
         USBEP_IDX_C_LIM_LO: begin
            rd_byte = s_ff.limit[7:0];
         end
         USBEP_IDX_C_CFG: begin
            rd_byte[USBEP_C_DIR] = s_ff.dir_in;
            rd_byte[USBEP_C_PERIODIC] = s_ff.periodic;
            rd_byte[USBEP_C_ISO] = s_ff.iso;
            rd_byte[USBEP_C_INDEX_HI:0] = s_ff.index;
         end
         default: begin
            // unmapped word answers with an error
            mapped = 1'b0;
         end
      endcase
   end

   // a write lands only at the edge where pready is seen high
   assign wr_fire = acc && s_ff.pready && pwrite && pstrb[0] && mapped;
   assign wr_ctrl = wr_fire && (idx == USBEP_IDX_B_CTRL);
   assign wr_lim_hi = wr_fire && (idx == USBEP_IDX_C_LIM_HI);
   assign wr_lim_lo = wr_fire && (idx == USBEP_IDX_C_LIM_LO);
   assign wr_cfg = wr_fire && (idx == USBEP_IDX_C_CFG);

   // a token seen this cycle already counts as a running transaction
   assign txn_busy = rpl_active || b_txn_start;
   assign b_good = b_txn_done && b_txn_ok;

   // next state of the block registers; reply and toggle submodules keep their own
   always_comb begin
      nxt_s = s_ff;
      nxt_s.tgl_one = 1'b0;
      nxt_s.tgl_zero = 1'b0;

      // apb: one wait state so read data leaves a flip-flop
      nxt_s.pready = 1'b0;
      nxt_s.pslverr = 1'b0;
      if (acc && !s_ff.pready) begin
         nxt_s.pready = 1'b1;
         nxt_s.pslverr = ~mapped;
         nxt_s.prdata = {24'h00_0000, rd_byte};
      end

      // plain read/write control bits
      if (wr_ctrl) begin
         nxt_s.auto_nak = wb[USBEP_B_AUTO_NAK];
         nxt_s.short_en = wb[USBEP_B_SHORT_EN];
         nxt_s.srx_dis = wb[USBEP_B_SRX_DIS];
         nxt_s.forced_halt = wb[USBEP_B_HALT];
         nxt_s.tgl_one = wb[USBEP_B_TGL_ONE];
         nxt_s.tgl_zero = wb[USBEP_B_TGL_ZERO];
         // hold off a nak set while busy
         if (wb[USBEP_B_NAK]) begin
            if (txn_busy) begin
               nxt_s.nak_pending = 1'b1;
            end else begin
               nxt_s.forced_nak = 1'b1;
            end
         end else begin
            // clearing also drops a held-off set
            nxt_s.forced_nak = 1'b0;
            nxt_s.nak_pending = 1'b0;
         end
      end

      // end of transaction on the second endpoint
      if (b_txn_done) begin
         if (s_ff.nak_pending) begin
            nxt_s.forced_nak = 1'b1;
            nxt_s.nak_pending = 1'b0;
         end
      end
      if (b_good) begin
         // auto nak checked first, takes priority
         if (s_ff.auto_nak) begin
            nxt_s.forced_nak = 1'b1;
         end else if (!s_ff.srx_dis && !b_dir_in && b_short) begin
            nxt_s.forced_nak = 1'b1;
         end
         // clear only after a short in packet
         if (b_dir_in && b_short &&
             !(wr_ctrl && wb[USBEP_B_SHORT_EN])) begin
            // a software set in the same cycle is kept
            nxt_s.short_en = 1'b0;
         end
      end

      // empty fifo plus short enable means zlp
      nxt_s.send_zlp = nxt_s.short_en && b_fifo_empty;

      // eleven bit limit split over two registers
      if (wr_lim_hi) begin
         nxt_s.limit[USBEP_LIM_W-1:8] = wb[USBEP_LIM_HI_W-1:0];
      end
      if (wr_lim_lo) begin
         nxt_s.limit[7:0] = wb;
      end

      // third endpoint configuration
      if (wr_cfg) begin
         // zero is out, one is in
         nxt_s.dir_in = wb[USBEP_C_DIR];
         nxt_s.periodic = wb[USBEP_C_PERIODIC];
         nxt_s.iso = wb[USBEP_C_ISO];
         // index taken as written; zero is a software fault
         nxt_s.index = wb[USBEP_C_INDEX_HI:0];
      end
      // mode bit on an out endpoint enables ping
      nxt_s.ping = !nxt_s.dir_in && nxt_s.periodic;
   end

   // state register, reset values from the register map
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_ff <= '0;
         s_ff.auto_nak <= USBEP_RST_B_CTRL[USBEP_B_AUTO_NAK];
         s_ff.short_en <= USBEP_RST_B_CTRL[USBEP_B_SHORT_EN];
         s_ff.srx_dis <= USBEP_RST_B_CTRL[USBEP_B_SRX_DIS];
         s_ff.forced_nak <= USBEP_RST_B_CTRL[USBEP_B_NAK];
         s_ff.forced_halt <= USBEP_RST_B_CTRL[USBEP_B_HALT];
         s_ff.limit <= {USBEP_RST_C_LIM_HI[USBEP_LIM_HI_W-1:0],
            USBEP_RST_C_LIM_LO};
         s_ff.dir_in <= USBEP_RST_C_CFG[USBEP_C_DIR];
         s_ff.periodic <= USBEP_RST_C_CFG[USBEP_C_PERIODIC];
         s_ff.iso <= USBEP_RST_C_CFG[USBEP_C_ISO];
         s_ff.index <= USBEP_RST_C_CFG[USBEP_C_INDEX_HI:0];
      end else begin
         s_ff <= nxt_s;
      end
   end

   // handshake choice for the second endpoint
   usbep_reply u_reply_b (
      .ref_clk(ref_clk),
      .srst(srst),
      .txn_start(b_txn_start),
      .txn_done(b_txn_done),
      .halt_level(s_ff.forced_halt),
      .nak_level(s_ff.forced_nak),
      .reply(rpl_code),
      .active(rpl_active)
   );

   // second endpoint toggle; its mode bit lives elsewhere, so normal
   usbep_toggle u_toggle_b (
      .ref_clk(ref_clk),
      .srst(srst),
      .force_one(s_ff.tgl_one),
      .force_zero(s_ff.tgl_zero),
      .txn_done(b_txn_done),
      .txn_ok(b_txn_ok),
      .always_mode(1'b0),
      .toggle(tgl_b)
   );

   // third endpoint toggle; always mode only for in
   usbep_toggle u_toggle_c (
      .ref_clk(ref_clk),
      .srst(srst),
      .force_one(1'b0),
      .force_zero(1'b0),
      .txn_done(c_txn_done),
      .txn_ok(c_txn_ok),
      .always_mode(s_ff.dir_in && s_ff.periodic),
      .toggle(tgl_c)
   );

   // outputs, each straight from a flip-flop
   assign prdata = s_ff.prdata;
   assign pready = s_ff.pready;
   assign pslverr = s_ff.pslverr;
   assign b_reply = rpl_code;
   assign b_send_short = s_ff.short_en;
   assign b_send_zlp = s_ff.send_zlp;
   assign b_toggle = tgl_b;
   assign c_packet_limit = s_ff.limit;
   assign c_dir_in = s_ff.dir_in;
   assign c_periodic_mode = s_ff.periodic;
   assign c_ping_enable = s_ff.ping;
   assign c_iso = s_ff.iso;
   assign c_index = s_ff.index;
   assign c_toggle = tgl_c;
endmodule
`default_nettype wire

/* rtl/usbep_pkg.sv */
// shared constants and types for the endpoint control block
package usbep_pkg;
   // apb address width and register word indices (byte address = 4*index)
   localparam int USBEP_ADDR_W = 12;
   localparam logic [9:0] USBEP_IDX_B_CTRL = 10'h104;
   localparam logic [9:0] USBEP_IDX_C_LIM_HI = 10'h108;
   localparam logic [9:0] USBEP_IDX_C_LIM_LO = 10'h109;
   localparam logic [9:0] USBEP_IDX_C_CFG = 10'h10a;
   // register reset values
   localparam logic [7:0] USBEP_RST_B_CTRL = 8'h00;
   localparam logic [7:0] USBEP_RST_C_LIM_HI = 8'h00;
   localparam logic [7:0] USBEP_RST_C_LIM_LO = 8'h00;
   localparam logic [7:0] USBEP_RST_C_CFG = 8'h00;
   // control register field positions
   localparam int USBEP_B_AUTO_NAK = 7;
   localparam int USBEP_B_SHORT_EN = 6;
   localparam int USBEP_B_SRX_DIS = 5;
   localparam int USBEP_B_TOGGLE = 4;
   localparam int USBEP_B_TGL_ONE = 3;
   localparam int USBEP_B_TGL_ZERO = 2;
   localparam int USBEP_B_NAK = 1;
   localparam int USBEP_B_HALT = 0;
   // configuration register field positions
   localparam int USBEP_C_DIR = 7;
   localparam int USBEP_C_PERIODIC = 6;
   localparam int USBEP_C_ISO = 5;
   localparam int USBEP_C_INDEX_HI = 3;
   // packet limit: high register carries bits 10..8 in its low three bits
   localparam int USBEP_LIM_W = 11;
   localparam int USBEP_LIM_HI_W = 3;
   // handshake the sie should give for the current transaction
   typedef enum logic [1:0] {
      USBEP_REPLY_NORMAL,
      USBEP_REPLY_NAK,
      USBEP_REPLY_STALL
   } usbep_reply_t;
endpackage

/* rtl/usbep_toggle.sv */
// data toggle sequence bit of one endpoint
`timescale 1ns/1ps
`default_nettype none
module usbep_toggle
   import usbep_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // software commands, one-cycle pulses
   input wire logic force_one,
   input wire logic force_zero,
   // transaction outcome from the sie
   input wire logic txn_done,
   input wire logic txn_ok,
   input wire logic always_mode,
   // current toggle
   output logic toggle
);
   typedef struct packed {
      logic toggle;
   } usbep_tgl_t;

   usbep_tgl_t s_ff, nxt_s;

   // next toggle: software commands beat the sequence advance
   always_comb begin
      nxt_s = s_ff;
      if (force_zero) begin
         nxt_s.toggle = 1'b0;
      end else if (force_one) begin
         nxt_s.toggle = 1'b1;
      // always mode flips whatever the outcome
      end else if (txn_done && (txn_ok || always_mode)) begin
         nxt_s.toggle = ~s_ff.toggle;
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign toggle = s_ff.toggle;
endmodule
`default_nettype wire

/* rtl/usbep_reply.sv */
// handshake selection latched per transaction
`timescale 1ns/1ps
`default_nettype none
module usbep_reply
   import usbep_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // transaction framing from the sie, one-cycle pulses
   input wire logic txn_start,
   input wire logic txn_done,
   // override levels from the control register
   input wire logic halt_level,
   input wire logic nak_level,
   // registered answer and busy flag
   output usbep_reply_t reply,
   output logic active
);
   typedef struct packed {
      usbep_reply_t reply;
      logic active;
   } usbep_rpl_t;

   usbep_rpl_t s_ff, nxt_s;

   // overrides are sampled at the token so a late write waits
   always_comb begin
      nxt_s = s_ff;
      if (txn_start) begin
         nxt_s.active = 1'b1;
         if (halt_level) begin
            nxt_s.reply = USBEP_REPLY_STALL;
         end else if (nak_level) begin
            nxt_s.reply = USBEP_REPLY_NAK;
         end else begin
            nxt_s.reply = USBEP_REPLY_NORMAL;
         end
      end else if (txn_done) begin
         nxt_s.active = 1'b0;
      end
      // idle answer tracks stall for the next token
      if (!nxt_s.active) begin
         nxt_s.reply = halt_level ? USBEP_REPLY_STALL :
            (nak_level ? USBEP_REPLY_NAK : USBEP_REPLY_NORMAL);
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_ff <= '{reply: USBEP_REPLY_NORMAL, active: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign reply = s_ff.reply;
   assign active = s_ff.active;
endmodule
`default_nettype wire

/* verif/usbep_ctrl_sva.sv */
// assertion checker bound to the endpoint control block
`timescale 1ns/1ps
`default_nettype none
module usbep_ctrl_sva
   import usbep_pkg::*;
#(
   parameter int ADDR_W = USBEP_ADDR_W
)(
   // clock, reset and apb
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   // second endpoint
   input wire logic b_txn_start,
   input wire logic b_txn_done,
   input wire usbep_reply_t b_reply,
   input wire logic b_toggle,
   // third endpoint
   input wire logic c_txn_done,
   input wire logic c_txn_ok,
   input wire logic [USBEP_LIM_W-1:0] c_packet_limit,
   input wire logic c_dir_in,
   input wire logic c_periodic_mode,
   input wire logic c_ping_enable,
   input wire logic c_iso,
   input wire logic [3:0] c_index,
   input wire logic c_toggle
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // transaction in flight, rebuilt from the event pulses
   logic busy_ff;
   logic wr_ok;
   logic wr_ctl;
   logic [ADDR_W-3:0] idx;
   assign idx = paddr[ADDR_W-1:2];
   // completed write with the low lane on
   assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
   assign wr_ctl = wr_ok && idx == USBEP_IDX_B_CTRL;
   // busy from start until done
   always_ff @(posedge ref_clk) begin
      busy_ff <= !srst && (b_txn_start || (busy_ff && !b_txn_done));
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_one_wait;
      !pready ##1 pready;
   endsequence
   AST_PREADY_ONE_WAIT: assert property (s_setup |=> s_one_wait)
      else $error("pready timing");
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("pready too long");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("stray pslverr");
   AST_REPLY_HOLD: assert property (
      busy_ff && $past(busy_ff) |-> $stable(b_reply))
      else $error("reply moved mid transaction");
   AST_STALL_IDLE: assert property (
      wr_ctl && pwdata[0] && !busy_ff
      && !b_txn_start |-> ##[1:2] b_reply == USBEP_REPLY_STALL)
      else $error("no stall");
   AST_NAK_IDLE: assert property (
      wr_ctl && pwdata[1:0] == 2'h2 && !busy_ff
      && !b_txn_start |-> ##[1:2] b_reply == USBEP_REPLY_NAK)
      else $error("no nak");
   AST_TOGGLE_ZERO: assert property (
      wr_ctl && pwdata[2] |-> ##[1:2] !b_toggle)
      else $error("toggle clear failed");
   AST_TOGGLE_ONE: assert property (
      wr_ctl && pwdata[3:2] == 2'h2 |-> ##[1:2] b_toggle)
      else $error("toggle set failed");
   AST_LIMIT_LOW: assert property (
      wr_ok && idx == USBEP_IDX_C_LIM_LO
      |=> c_packet_limit[7:0] == $past(pwdata[7:0]))
      else $error("limit low wrong");
   AST_LIMIT_HIGH: assert property (
      wr_ok && idx == USBEP_IDX_C_LIM_HI
      |=> c_packet_limit[10:8] == $past(pwdata[2:0]))
      else $error("limit high wrong");
   AST_CONFIG: assert property (
      wr_ok && idx == USBEP_IDX_C_CFG |=> c_dir_in == $past(pwdata[7])
      && c_iso == $past(pwdata[5]) && c_index == $past(pwdata[3:0]))
      else $error("config wrong");
   AST_PING: assert property (
      c_ping_enable == (!c_dir_in && c_periodic_mode))
      else $error("ping enable wrong");
   AST_ALWAYS_TOGGLE: assert property (
      c_txn_done && c_dir_in && c_periodic_mode
      |=> c_toggle != $past(c_toggle))
      else $error("toggle not flipped");
   AST_NORMAL_HOLD: assert property (
      c_txn_done && !c_txn_ok && !(c_dir_in && c_periodic_mode)
      |=> $stable(c_toggle))
      else $error("toggle flipped on error");
endmodule
bind usbep_ctrl usbep_ctrl_sva #(.ADDR_W(ADDR_W)) usbep_ctrl_sva_i (
   .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .pslverr(pslverr), .b_txn_start(b_txn_start),
   .b_txn_done(b_txn_done), .b_reply(b_reply), .b_toggle(b_toggle),
   .c_txn_done(c_txn_done), .c_txn_ok(c_txn_ok),
   .c_packet_limit(c_packet_limit), .c_dir_in(c_dir_in),
   .c_periodic_mode(c_periodic_mode), .c_ping_enable(c_ping_enable),
   .c_iso(c_iso), .c_index(c_index), .c_toggle(c_toggle)
);
`default_nettype wire

/* verif/usbep_host_model.sv */
// bus-side host model for the second endpoint
`timescale 1ns/1ps
`default_nettype none
module usbep_host_model
   import usbep_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // command from the bench
   input wire logic req,
   input wire logic [3:0] len,
   input wire logic ok,
   input wire logic short_pkt,
   // transaction events toward the block
   output logic b_txn_start,
   output logic b_txn_done,
   output logic b_txn_ok,
   output logic b_short,
   output logic busy
);
   logic [3:0] cnt_ff;
   // start, wait len cycles, then done with its qualifiers
   always_ff @(posedge ref_clk) begin
      b_txn_start <= 1'b0;
      b_txn_done <= 1'b0;
      // qualifiers mean nothing outside done, so keep them moving
      b_txn_ok <= ~b_txn_ok;
      b_short <= ~b_short;
      if (srst) begin
         busy <= 1'b0;
         cnt_ff <= 4'h0;
         b_txn_ok <= 1'b0;
         b_short <= 1'b0;
      end else if (req && !busy) begin
         b_txn_start <= 1'b1;
         busy <= 1'b1;
         cnt_ff <= len;
      end else if (busy && cnt_ff == 4'h0) begin
         b_txn_done <= 1'b1;
         b_txn_ok <= ok;
         b_short <= short_pkt;
         busy <= 1'b0;
      end else if (busy) begin
         cnt_ff <= cnt_ff - 4'h1;
      end
   end
endmodule
`default_nettype wire

/* verif/usbep_ctrl_bench.sv */
// self-checking bench for the endpoint control block
`timescale 1ns/1ps
`default_nettype none
module usbep_ctrl_bench
   import usbep_pkg::*;
;
   // clock, reset and apb master
   logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   // bus-side model and sie levels
   logic req, ok, shrt, busy, b_dir_in, b_fifo_empty;
   logic [3:0] len;
   logic b_txn_start, b_txn_done, b_txn_ok, b_short;
   usbep_reply_t b_reply;
   logic b_send_short, b_send_zlp, b_toggle, c_txn_done, c_txn_ok;
   logic [10:0] c_packet_limit;
   logic c_dir_in, c_periodic_mode, c_ping_enable, c_iso, c_toggle;
   logic [3:0] c_index;
   int fail_count = 0;
   int checks_done = 0;
   usbep_ctrl #(.ADDR_W(12)) usbep_ctrl_i (
      .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .b_txn_start(b_txn_start), .b_txn_done(b_txn_done),
      .b_txn_ok(b_txn_ok), .b_dir_in(b_dir_in), .b_short(b_short),
      .b_fifo_empty(b_fifo_empty), .b_reply(b_reply),
      .b_send_short(b_send_short), .b_send_zlp(b_send_zlp),
      .b_toggle(b_toggle), .c_txn_done(c_txn_done), .c_txn_ok(c_txn_ok),
      .c_packet_limit(c_packet_limit), .c_dir_in(c_dir_in),
      .c_periodic_mode(c_periodic_mode), .c_ping_enable(c_ping_enable),
      .c_iso(c_iso), .c_index(c_index), .c_toggle(c_toggle));
   usbep_host_model usbep_host_model_i (
      .ref_clk(ref_clk), .srst(srst), .req(req), .len(len), .ok(ok),
      .short_pkt(shrt), .b_txn_start(b_txn_start), .b_txn_done(b_txn_done),
      .b_txn_ok(b_txn_ok), .b_short(b_short), .busy(busy));
   // 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; waits for pready, then one idle edge
   task automatic apb(input logic [9:0] idx, input logic wr,
         input logic [7:0] wd);
      int n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h00_0000, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) fail_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   // start a transaction; fin waits for it to end
   task automatic go(input logic o, input logic s);
      req <= 1'b1;
      ok <= o;
      shrt <= s;
      @(posedge ref_clk);
      req <= 1'b0;
   endtask
   task automatic fin;
      int n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (busy !== 1'b0 && n < 40);
      if (n >= 40) fail_count++;
      tick(2);
   endtask
   task automatic cpulse(input logic o);
      c_txn_done <= 1'b1;
      c_txn_ok <= o;
      @(posedge ref_clk);
      c_txn_done <= 1'b0;
      c_txn_ok <= ~o;
      tick(2);
   endtask
   task automatic t_regs;
      logic [9:0] ids [4] = '{USBEP_IDX_B_CTRL, USBEP_IDX_C_LIM_HI,
         USBEP_IDX_C_LIM_LO, USBEP_IDX_C_CFG};
      foreach (ids[i]) begin
         apb(ids[i], 1'b0, 8'h00);
         chk(rd, 32'h0000_0000);
      end
      // unmapped place answers with an error
      apb(10'h0ff, 1'b1, 8'hff);
      chk(32'(err), 32'h0000_0001);
      $display("test regs done");
   endtask
   task automatic t_limit;
      apb(USBEP_IDX_C_LIM_HI, 1'b1, 8'hf8);
      apb(USBEP_IDX_C_LIM_LO, 1'b1, 8'h40);
      pstrb <= 4'h0;
      apb(USBEP_IDX_C_LIM_LO, 1'b1, 8'h11);
      pstrb <= 4'hf;
      chk(32'(c_packet_limit), 32'h0000_0040);
      apb(USBEP_IDX_C_LIM_HI, 1'b0, 8'h00);
      chk(rd, 32'h0000_0000);
      apb(USBEP_IDX_C_LIM_HI, 1'b1, 8'h04);
      apb(USBEP_IDX_C_LIM_LO, 1'b1, 8'h00);
      chk(32'(c_packet_limit), 32'h0000_0400);
      $display("test limit done");
   endtask
   task automatic t_config;
      logic [7:0] cf [3] = '{8'h81, 8'h4f, 8'ha3};
      logic t0;
      foreach (cf[i]) begin
         apb(USBEP_IDX_C_CFG, 1'b1, cf[i]);
         chk({c_dir_in,c_periodic_mode,c_iso,1'b0,c_index}, cf[i]);
         chk(32'(c_ping_enable), cf[i][7:6] == 2'h1);
      end
      apb(USBEP_IDX_C_CFG, 1'b1, 8'hc1);
      t0 = c_toggle;
      cpulse(1'b0);
      chk(32'(c_toggle), 32'(!t0));
      apb(USBEP_IDX_C_CFG, 1'b1, 8'h81);
      cpulse(1'b0);
      chk(32'(c_toggle), 32'(!t0));
      cpulse(1'b1);
      chk(32'(c_toggle), 32'(t0));
      $display("test config done");
   endtask
   task automatic t_toggle;
      logic [7:0] wv [4] = '{8'h08, 8'h0c, 8'h08, 8'h04};
      foreach (wv[i]) begin
         apb(USBEP_IDX_B_CTRL, 1'b1, wv[i]);
         tick(2);
         chk(32'(b_toggle), wv[i] == 8'h08);
         apb(USBEP_IDX_B_CTRL, 1'b0, 8'h00);
         chk(rd, {27'h000_0000, wv[i] == 8'h08, 4'h0});
      end
      $display("test toggle done");
   endtask
   task automatic t_stall;
      apb(USBEP_IDX_B_CTRL, 1'b1, 8'h03);
      tick(2);
      chk(32'(b_reply), USBEP_REPLY_STALL);
      apb(USBEP_IDX_B_CTRL, 1'b1, 8'h02);
      tick(2);
      chk(32'(b_reply), USBEP_REPLY_NAK);
      apb(USBEP_IDX_B_CTRL, 1'b1, 8'h00);
      // stall and nak written while a transaction runs
      go(1'b0, 1'b0);
      apb(USBEP_IDX_B_CTRL, 1'b1, 8'h03);
      apb(USBEP_IDX_B_CTRL, 1'b0, 8'h00);
      chk(rd, 32'h0000_0001);
      chk(32'(b_reply), USBEP_REPLY_NORMAL);
      fin();
      apb(USBEP_IDX_B_CTRL, 1'b0, 8'h00);
      chk(rd, 32'h0000_0003);
      go(1'b0, 1'b0);
      tick(2);
      chk(32'(b_reply), USBEP_REPLY_STALL);
      fin();
      apb(USBEP_IDX_B_CTRL, 1'b1, 8'h00);
      $display("test stall done");
   endtask
   task automatic t_auto;
      logic [7:0] cw [7] = '{8'h84, 8'h04, 8'h24, 8'ha4, 8'h44, 8'h44,
         8'h04};
      logic [2:0] fl [7] = '{3'h6, 3'h3, 3'h3, 3'h3, 3'h6, 3'h7, 3'h1};
      logic [7:0] ex [7] = '{8'h92, 8'h12, 8'h30, 8'hb2, 8'h50, 8'h10,
         8'h00};
      // each row: control word, {in, ok, short}, control after
      foreach (cw[i]) begin
         {b_dir_in, b_fifo_empty} <= {fl[i][2], fl[i][0]};
         apb(USBEP_IDX_B_CTRL, 1'b1, cw[i]);
         tick(2);
         chk({b_send_short, b_send_zlp}, cw[i][6] * {1'b1, fl[i][0]});
         go(fl[i][1], fl[i][0]);
         fin();
         apb(USBEP_IDX_B_CTRL, 1'b0, 8'h00);
         chk(rd, 32'(ex[i]));
      end
      $display("test auto done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      srst = 1'b1;
      {psel, penable, pwrite, req, ok, shrt, b_dir_in} = 7'h00;
      {c_txn_done, c_txn_ok} = 2'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hf;
      len = 4'hf;
      b_fifo_empty = 1'b1;
      tick(3);
      srst <= 1'b0;
      tick(1);
      t_regs();
      t_limit();
      t_config();
      t_toggle();
      t_stall();
      t_auto();
      report_and_stop();
   end
   // watchdog against a hung handshake
   initial begin
      tick(4000);
      fail_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
